// ---- design/sptc_top.sv ----
////////////////////////////////////////////////////////////////////////////////
module sptc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                rdy;
    logic                vld;
  } sptc_fifo_state_t;

  sptc_fifo_state_t s_reg;
  sptc_fifo_state_t s_next;
  logic push;
  logic pop;

  assign push        = in_valid_i && s_reg.rdy;
  assign pop         = out_ready_i && s_reg.vld;
  assign in_ready_o  = s_reg.rdy;
  assign out_valid_o = s_reg.vld;
  assign out_data_o  = s_reg.mem[s_reg.rp];

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wp] = in_data_i;
      s_next.wp = (s_reg.wp == AW'(D - 1)) ? '0 : s_reg.wp + AW'(1);
    end
    if (pop) begin
      s_next.rp = (s_reg.rp == AW'(D - 1)) ? '0 : s_reg.rp + AW'(1);
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // flags kept as flops so ready and valid never ride on a comparator
    s_next.rdy = (s_next.cnt != (AW+1)'(D));
    s_next.vld = (s_next.cnt != '0);
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg     <= '0;
      s_reg.rdy <= 1'b1;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Function
// - sixteen stp states per port, filter id bits
// - each instance acts independently of others
// - disabled: drop all but bpdu, never learn
// - blocking/listening: discard, no learning, bpdu passes
// - learning: discard traffic but learn sources
// - forwarding: pass all frames normally
// - bpdu recognised by its group address
// - bpdu bypasses states to management port
// - reserved block discards reserved group range
// - full duplex sends and honours pause
// - half duplex forces collision by jam
// - per-port enable, gated by autonegotiation result
// - on by any trigger, off when all clear
// - global trigger with upper/lower thresholds
// - per-port local trigger with hysteresis
// - metering trigger on fill and rate
// - trunk holds two ports, any numbering
// - trunk ingress maps to lower port
// - egress spread by flow action or hash
// - masked hash key of four bytes
// - failed member excluded, its queue flushed
// - slower member treated as link down
module sptc_top #(
  parameter int PORTS = 7,
  parameter int PW    = 3,
  parameter int FIDW  = 6,
  parameter int LW    = 12
) (
  input  wire logic                                      clock_i,
  input  wire logic                                      rst_n_i,
  input  wire logic                                      ce_i,
  input  wire logic [PORTS-1:0][sptc_pkg::STP_INST-1:0][1:0] stp_state_i,
  input  wire logic                                      stp_enable_i,
  input  wire logic [PW-1:0]                             mgmt_port_i,
  input  wire logic                                      rsvd_block_i,
  input  wire logic                                      frm_valid_i,
  output logic                                           frm_ready_o,
  input  wire logic [PW-1:0]                             frm_in_port_i,
  input  wire logic [PW-1:0]                             frm_dst_port_i,
  input  wire logic [FIDW-1:0]                           filter_id_i,
  input  wire logic [47:0]                               frm_dst_mac_i,
  input  wire logic [47:0]                               frm_src_mac_i,
  input  wire logic                                      frm_is_ip_i,
  input  wire logic [31:0]                               frm_dst_ip_i,
  input  wire logic [31:0]                               frm_src_ip_i,
  input  wire logic                                      flow_dist_valid_i,
  input  wire logic                                      flow_dist_high_i,
  output logic                                           out_valid_o,
  input  wire logic                                      out_ready_i,
  output logic                                           out_forward_o,
  output logic                                           out_learn_o,
  output logic                                           out_to_mgmt_o,
  output logic [PW-1:0]                                  out_ingress_port_o,
  output logic [PW-1:0]                                  out_egress_port_o,
  input  wire logic                                      trunk_enable_i,
  input  wire logic [PW-1:0]                             trunk_low_port_i,
  input  wire logic [PW-1:0]                             trunk_high_port_i,
  input  wire logic                                      hash_mask_dst_mac_i,
  input  wire logic                                      hash_mask_src_mac_i,
  input  wire logic                                      hash_mask_dst_ip_i,
  input  wire logic                                      hash_mask_src_ip_i,
  input  wire logic [PORTS-1:0]                          link_up_i,
  input  wire logic [PORTS-1:0][1:0]                     link_speed_i,
  output logic [PORTS-1:0]                               queue_flush_o,
  input  wire logic [PORTS-1:0]                          fc_enable_i,
  input  wire logic [PORTS-1:0]                          aneg_fc_ok_i,
  input  wire logic [PORTS-1:0]                          full_duplex_i,
  input  wire logic [LW-1:0]                             glob_level_i,
  input  wire logic [LW-1:0]                             glob_fc_on_threshold_i,
  input  wire logic [LW-1:0]                             glob_fc_off_threshold_i,
  input  wire logic [PORTS-1:0][LW-1:0]                  port_level_i,
  input  wire logic [LW-1:0]                             port_fc_on_threshold_i,
  input  wire logic [LW-1:0]                             port_fc_off_threshold_i,
  input  wire logic [LW-1:0]                             meter_fc_on_threshold_i,
  input  wire logic [LW-1:0]                             meter_fc_off_threshold_i,
  input  wire logic [PORTS-1:0]                          rate_exceeded_i,
  output logic [PORTS-1:0]                               fc_active_o,
  output logic [PORTS-1:0]                               pause_send_o,
  output logic [PORTS-1:0]                               jam_send_o,
  output logic [PORTS-1:0]                               pause_honour_o
);
  localparam int DW = 3 + 2 * PW;

  typedef struct packed {
    logic                 fc_glob;
    logic [PORTS-1:0]     fc_port;
    logic [PORTS-1:0]     fc_meter;
    logic [PORTS-1:0]     fc_act;
    logic [PORTS-1:0]     pause;
    logic [PORTS-1:0]     jam;
    logic [PORTS-1:0]     honour;
    logic [PORTS-1:0]     usable;
    logic [PORTS-1:0]     flush;
    logic                 ov;
    logic [DW-1:0]        od;
  } sptc_state_t;

  sptc_state_t s_reg;
  sptc_state_t s_next;

  //////////////////////////////////////////////////////////////////////////////
  logic [sptc_pkg::STP_IDX_W-1:0]  inst;
  logic [PW-1:0]                   ing;
  logic [PW-1:0]                   egr;
  logic [1:0]                      st_in;
  logic [1:0]                      st_eg;
  logic                            bpdu;
  logic                            rsvd;
  logic [sptc_pkg::HASH_KEY_W-1:0] key;
  logic                            pick_high;
  logic                            dec_fwd;
  logic                            dec_learn;
  logic [PW-1:0]                   dec_port;
  logic [PORTS-1:0]                usable_now;
  logic                            fifo_in_ready;
  logic                            fifo_out_valid;
  logic [DW-1:0]                   fifo_out_data;
  logic                            fifo_pop;

  assign inst = filter_id_i[sptc_pkg::STP_IDX_W-1:0];
  assign bpdu = stp_enable_i && (frm_dst_mac_i == sptc_pkg::BPDU_MAC);
  assign rsvd = frm_dst_mac_i[47:sptc_pkg::RSVD_LSB] == sptc_pkg::RSVD_PREFIX;
  // both members collapse onto the lower port on ingress
  assign ing = (trunk_enable_i && frm_in_port_i == trunk_high_port_i)
             ? trunk_low_port_i : frm_in_port_i;

  // masked or non-ip fields feed zeros into the key
  assign key = {hash_mask_dst_mac_i ? 8'h00 : frm_dst_mac_i[sptc_pkg::HASH_FLD_W-1:0],
                hash_mask_src_mac_i ? 8'h00 : frm_src_mac_i[sptc_pkg::HASH_FLD_W-1:0],
                (hash_mask_dst_ip_i || !frm_is_ip_i) ? 8'h00
                  : frm_dst_ip_i[sptc_pkg::HASH_FLD_W-1:0],
                (hash_mask_src_ip_i || !frm_is_ip_i) ? 8'h00
                  : frm_src_ip_i[sptc_pkg::HASH_FLD_W-1:0]};

  // a member is usable when up and not the slower of the pair
  always_comb begin
    usable_now = link_up_i;
    if (trunk_enable_i) begin
      if (link_speed_i[trunk_low_port_i] < link_speed_i[trunk_high_port_i]) begin
        usable_now[trunk_low_port_i] = 1'b0;
      end
      if (link_speed_i[trunk_high_port_i] < link_speed_i[trunk_low_port_i]) begin
        usable_now[trunk_high_port_i] = 1'b0;
      end
    end
  end

  always_comb begin
    pick_high = flow_dist_valid_i ? flow_dist_high_i : ^key;
    egr = frm_dst_port_i;
    if (trunk_enable_i && frm_dst_port_i == trunk_low_port_i) begin
      if (!usable_now[trunk_high_port_i]) begin
        egr = trunk_low_port_i;
      end else if (!usable_now[trunk_low_port_i]) begin
        egr = trunk_high_port_i;
      end else begin
        egr = pick_high ? trunk_high_port_i : trunk_low_port_i;
      end
    end
  end

  // state lookup uses only this frame's instance, so others never interfere
  assign st_in = stp_state_i[ing][inst];
  assign st_eg = stp_state_i[egr][inst];

  always_comb begin
    dec_learn = (st_in == sptc_pkg::STP_LEARNING) || (st_in == sptc_pkg::STP_FORWARD);
    dec_fwd   = (st_in == sptc_pkg::STP_FORWARD) && (st_eg == sptc_pkg::STP_FORWARD);
    dec_port  = egr;
    if (rsvd_block_i && rsvd) begin
      dec_fwd = 1'b0;
    end
    // bpdu rule overrides both port states and the reserved discard
    if (bpdu) begin
      dec_fwd  = 1'b1;
      dec_port = mgmt_port_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  sptc_fifo #(
    .W (DW),
    .D (sptc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_valid_i  (frm_valid_i),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({dec_fwd, dec_learn, bpdu, ing, dec_port}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

  assign frm_ready_o = fifo_in_ready;
  assign fifo_pop    = !s_reg.ov || out_ready_i;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    // hysteresis: between the two thresholds each trigger keeps its value, the meter trigger only while its rate stays exceeded
    if (glob_level_i > glob_fc_on_threshold_i) begin
      s_next.fc_glob = 1'b1;
    end else if (glob_level_i < glob_fc_off_threshold_i) begin
      s_next.fc_glob = 1'b0;
    end
    for (int p = 0; p < PORTS; p++) begin
      if (port_level_i[p] > port_fc_on_threshold_i) begin
        s_next.fc_port[p] = 1'b1;
      end else if (port_level_i[p] < port_fc_off_threshold_i) begin
        s_next.fc_port[p] = 1'b0;
      end
      if (glob_level_i < meter_fc_off_threshold_i || !rate_exceeded_i[p]) begin
        s_next.fc_meter[p] = 1'b0;
      end else if (glob_level_i > meter_fc_on_threshold_i) begin
        s_next.fc_meter[p] = 1'b1;
      end
      s_next.fc_act[p] = fc_enable_i[p] && aneg_fc_ok_i[p]
                       && (s_next.fc_glob || s_next.fc_port[p] || s_next.fc_meter[p]);
      s_next.pause[p]  = s_next.fc_act[p] && full_duplex_i[p];
      s_next.jam[p]    = s_next.fc_act[p] && !full_duplex_i[p];
      s_next.honour[p] = fc_enable_i[p] && aneg_fc_ok_i[p] && full_duplex_i[p];
    end
    s_next.usable = usable_now;
    // one-cycle flush when a trunk member drops out of distribution
    s_next.flush = '0;
    if (trunk_enable_i) begin
      s_next.flush[trunk_low_port_i]  = s_reg.usable[trunk_low_port_i]
                                       && !usable_now[trunk_low_port_i];
      s_next.flush[trunk_high_port_i] = s_reg.usable[trunk_high_port_i]
                                       && !usable_now[trunk_high_port_i];
    end
    if (fifo_pop) begin
      s_next.ov = fifo_out_valid;
      if (fifo_out_valid) begin
        s_next.od = fifo_out_data;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  assign out_valid_o        = s_reg.ov;
  assign out_forward_o      = s_reg.od[DW-1];
  assign out_learn_o        = s_reg.od[DW-2];
  assign out_to_mgmt_o      = s_reg.od[DW-3];
  assign out_ingress_port_o = s_reg.od[2*PW-1:PW];
  assign out_egress_port_o  = s_reg.od[PW-1:0];
  assign queue_flush_o      = s_reg.flush;
  assign fc_active_o        = s_reg.fc_act;
  assign pause_send_o       = s_reg.pause;
  assign jam_send_o         = s_reg.jam;
  assign pause_honour_o     = s_reg.honour;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  logic in_fire;
  assign in_fire = frm_valid_i && frm_ready_o && ce_i;

  disabled_drop_a: assert property (in_fire && st_in == sptc_pkg::STP_DISABLED
    && !bpdu |-> !dec_fwd && !dec_learn) else $error("disabled port passed or learned");
  blocking_nolearn_a: assert property (in_fire && st_in == sptc_pkg::STP_BLOCKING
    |-> !dec_learn && (dec_fwd == bpdu)) else $error("blocking state leak");
  learning_state_a: assert property (in_fire && st_in == sptc_pkg::STP_LEARNING
    |-> dec_learn && (dec_fwd == bpdu)) else $error("learning state wrong");
  bpdu_to_mgmt_a: assert property (in_fire && bpdu
    |-> dec_fwd && dec_port == mgmt_port_i) else $error("bpdu not sent to management");
  rsvd_discard_a: assert property (in_fire && rsvd_block_i && rsvd && !bpdu
    |-> !dec_fwd) else $error("reserved frame forwarded");
  trunk_ingress_a: assert property (in_fire && trunk_enable_i
    && frm_in_port_i == trunk_high_port_i |-> ing == trunk_low_port_i)
    else $error("trunk ingress not mapped low");
  trunk_failover_a: assert property (in_fire && trunk_enable_i && !bpdu
    && frm_dst_port_i == trunk_low_port_i && !link_up_i[trunk_high_port_i]
    |-> dec_port == trunk_low_port_i) else $error("traffic sent to failed member");
  fc_enable_gate_a: assert property (ce_i
    |=> ((fc_active_o | pause_send_o | jam_send_o | pause_honour_o)
    & ~($past(fc_enable_i) & $past(aneg_fc_ok_i))) == '0)
    else $error("flow control on a disabled port");
  port_fc_on_a: assert property (ce_i && fc_enable_i[0] && aneg_fc_ok_i[0]
    && port_level_i[0] > port_fc_on_threshold_i |=> fc_active_o[0])
    else $error("local trigger did not start flow control");
  flush_pulse_a: assert property (ce_i && trunk_enable_i && link_up_i[trunk_high_port_i]
    && link_speed_i[trunk_high_port_i] >= link_speed_i[trunk_low_port_i]
    ##1 ce_i && trunk_enable_i && $stable(trunk_high_port_i) && !link_up_i[trunk_high_port_i]
    |=> queue_flush_o[trunk_high_port_i]) else $error("failed member not flushed");

  bpdu_seen_c: cover property (in_fire && bpdu);
  trunk_high_c: cover property (in_fire && trunk_enable_i && dec_port == trunk_high_port_i);
  fc_pause_c: cover property (pause_send_o[0] ##1 !pause_send_o[0]);
  fifo_full_c: cover property (frm_valid_i && !frm_ready_o);
endmodule

// ---- design/sptc_pkg.sv ----
package sptc_pkg;

  // spanning-tree instances per port and index bits taken from the filter id
  localparam int STP_INST      = 16;
  localparam int STP_IDX_W     = 4;

  // per-instance port state encoding
  localparam logic [1:0] STP_DISABLED = 2'h0;
  localparam logic [1:0] STP_BLOCKING = 2'h1;
  localparam logic [1:0] STP_LEARNING = 2'h2;
  localparam logic [1:0] STP_FORWARD  = 2'h3;

  // bridge protocol group address and reserved group range prefix
  localparam logic [47:0] BPDU_MAC    = 48'h0180c2000000;
  localparam logic [39:0] RSVD_PREFIX = 40'h0180c20000;
  localparam int          RSVD_LSB    = 8;

  // trunk hash key layout
  localparam int HASH_KEY_W  = 32;
  localparam int HASH_FLD_W  = 8;

  // fifo in the decision path
  localparam int FIFO_DEPTH  = 8;

endpackage

// ---- tb/sptc_sink.sv ----
////////////////////////////////////////////////////////////////////////////////
// decision consumer; stall_i holds ready low to back up the fifo
module sptc_sink (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       stall_i,
  input  wire logic       valid_i,
  output logic            ready_o,
  input  wire logic [8:0] dec_i,
  output logic            got_o,
  output logic [8:0]      last_o
);
  timeunit 1ns;
  timeprecision 1ns;
  assign ready_o = !stall_i;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      got_o  <= 1'b0;
      last_o <= 9'h000;
    end else begin
      got_o <= valid_i && ready_o;
      if (valid_i && ready_o) begin
        last_o <= dec_i;
      end
    end
  end
endmodule

// ---- tb/tb_sptc_top.sv ----
////////////////////////////////////////////////////////////////////////////////
module tb_sptc_top;
  timeunit 1ns;
  timeprecision 1ns;
  // m = {dmac, smac, dst ip, src ip} masks; e = {forward, learn, to_mgmt}
  typedef struct packed {
    logic [1:0] st; logic [2:0] ip, dp; logic [5:0] fi; logic [47:0] dm;
    logic [7:0] s, d; logic ipf; logic [3:0] m; logic [1:0] fl, ctl;
    logic [2:0] e, ei, ee;
  } sptc_row_t;
  localparam logic [47:0] BP = sptc_pkg::BPDU_MAC;
  logic clock_i = 1'b0, rst_n_i = 1'b0, stall = 1'b0, fv = 1'b0;
  logic [6:0][15:0][1:0] stp;
  logic stp_en, rsvd, frdy, is_ip, flv, flh, ov, ordy, fwd, lrn, mg, got;
  logic [2:0] inp, dstp, ing, egr;
  logic [5:0] filt;
  logic [47:0] dmac, smac;
  logic [31:0] dst_ip, src_ip;
  logic [3:0] msk;
  logic [6:0] lup, fce, ang, fdx, rex, flush, fca, ps, jm, ph;
  logic [6:0][1:0] spd;
  logic [11:0] gl, gon, gof, pon, pof, mon, mof;
  logic [6:0][11:0] pl;
  logic [8:0] last;
  int error_cnt = 0, comparisons = 0;
  sptc_row_t rows [21] = '{
    '{3, 2, 3, 6'h25, 0, 0, 0, 0, 0, 0, 0, 6, 2, 3}, '{0, 2, 3, 5, 0, 0, 0, 0, 0, 0, 0, 0, 2, 3},
    '{1, 2, 3, 5, 0, 0, 0, 0, 0, 0, 0, 0, 2, 3}, '{2, 2, 3, 5, 0, 0, 0, 0, 0, 0, 0, 2, 2, 3},
    '{1, 2, 3, 5, BP, 0, 0, 0, 0, 0, 2, 5, 2, 6}, '{2, 2, 3, 9, BP, 0, 0, 0, 0, 0, 3, 7, 2, 6},
    '{3, 2, 3, 9, BP, 0, 0, 0, 0, 0, 0, 6, 2, 3},
    '{3, 2, 3, 9, 48'h0180c20000ff, 0, 0, 0, 0, 0, 1, 2, 2, 3},
    '{3, 2, 3, 9, 48'h0180c2000100, 0, 0, 0, 0, 0, 1, 6, 2, 3},
    '{3, 4, 2, 9, 0, 0, 0, 0, 0, 0, 0, 6, 1, 2}, '{3, 2, 1, 9, 1, 0, 0, 1, 0, 0, 0, 6, 2, 4},
    '{3, 2, 1, 9, 3, 0, 0, 1, 0, 0, 0, 6, 2, 1}, '{3, 2, 1, 9, 1, 1, 0, 1, 0, 0, 0, 6, 2, 1},
    '{3, 2, 1, 9, 1, 1, 0, 1, 4, 0, 0, 6, 2, 4}, '{3, 2, 1, 9, 0, 0, 1, 0, 0, 0, 0, 6, 2, 1},
    '{3, 2, 1, 9, 0, 0, 1, 1, 2, 0, 0, 6, 2, 4}, '{3, 2, 1, 9, 0, 0, 1, 1, 1, 0, 0, 6, 2, 4},
    '{3, 2, 1, 9, 0, 0, 1, 1, 0, 0, 0, 6, 2, 1}, '{3, 2, 1, 9, 1, 0, 0, 1, 8, 0, 0, 6, 2, 1},
    '{3, 2, 1, 9, 0, 0, 0, 1, 0, 3, 0, 6, 2, 4}, '{3, 2, 1, 9, 1, 0, 0, 1, 0, 2, 0, 6, 2, 1}};

  always #25 clock_i = ~clock_i;

  sptc_top u_sptc_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .stp_state_i(stp),
    .stp_enable_i(stp_en), .mgmt_port_i(3'h6), .rsvd_block_i(rsvd), .frm_valid_i(fv),
    .frm_ready_o(frdy), .frm_in_port_i(inp), .frm_dst_port_i(dstp), .filter_id_i(filt),
    .frm_dst_mac_i(dmac), .frm_src_mac_i(smac), .frm_is_ip_i(is_ip), .frm_dst_ip_i(dst_ip),
    .frm_src_ip_i(src_ip), .flow_dist_valid_i(flv), .flow_dist_high_i(flh), .out_valid_o(ov),
    .out_ready_i(ordy), .out_forward_o(fwd), .out_learn_o(lrn), .out_to_mgmt_o(mg),
    .out_ingress_port_o(ing), .out_egress_port_o(egr), .trunk_enable_i(1'b1),
    .trunk_low_port_i(3'h1), .trunk_high_port_i(3'h4), .hash_mask_dst_mac_i(msk[3]),
    .hash_mask_src_mac_i(msk[2]), .hash_mask_dst_ip_i(msk[1]), .hash_mask_src_ip_i(msk[0]),
    .link_up_i(lup), .link_speed_i(spd), .queue_flush_o(flush), .fc_enable_i(fce),
    .aneg_fc_ok_i(ang), .full_duplex_i(fdx), .glob_level_i(gl), .glob_fc_on_threshold_i(gon),
    .glob_fc_off_threshold_i(gof), .port_level_i(pl), .port_fc_on_threshold_i(pon),
    .port_fc_off_threshold_i(pof), .meter_fc_on_threshold_i(mon),
    .meter_fc_off_threshold_i(mof), .rate_exceeded_i(rex), .fc_active_o(fca),
    .pause_send_o(ps), .jam_send_o(jm), .pause_honour_o(ph));

  sptc_sink u_sptc_sink (.clock_i(clock_i), .rst_n_i(rst_n_i), .stall_i(stall),
    .valid_i(ov), .ready_o(ordy), .dec_i({fwd, lrn, mg, ing, egr}), .got_o(got),
    .last_o(last));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // inputs move 2 ns after the rising edge
  task automatic tk(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask

  task automatic wait_got;
    int n;
    n = 0;
    do begin tk(1); n++; end while (got !== 1'b1 && n < 20);
    chk(got, 1'b1);
  endtask

  // descriptor held until an edge that sees ready high
  task automatic run(input sptc_row_t r);
    logic ok;
    for (int p = 0; p < 7; p++)
      for (int k = 0; k < 16; k++) stp[p][k] = (k == r.fi[3:0]) ? r.st : ~r.st;
    {stp_en, rsvd} = r.ctl;
    inp = r.ip; dstp = r.dp; filt = r.fi; dmac = r.dm; smac = {40'h0, r.s};
    dst_ip = {24'h0, r.d}; src_ip = {24'h0, r.d[3:0], r.d[7:4]}; is_ip = r.ipf;
    msk = r.m; {flv, flh} = r.fl; fv = 1'b1; ok = 1'b0;
    while (!ok) begin ok = frdy; tk(1); end
    fv = 1'b0;
    wait_got();
    chk(last, {r.e, r.ei, r.ee});
  endtask

  task automatic flush_chk(input int p);
    int c;
    logic [6:0] o;
    c = 0; o = 7'h00;
    repeat (4) begin
      tk(1);
      if (flush[p] === 1'b1) c++;
      o |= flush & ~(7'h01 << p);
    end
    chk(c, 1);
    chk(o, 0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    logic ok;
    sptc_row_t r;
    stp = '0; {stp_en, rsvd, is_ip, flv, flh} = '0; {inp, dstp, filt, msk} = '0;
    dmac = '0; smac = '0; dst_ip = '0; src_ip = '0; lup = 7'h7f; spd = '1; rex = '0; pl = '0;
    fce = 7'h77; ang = 7'h7b; fdx = 7'h7d; gl = '0; gon = 12'h800; gof = 12'h700;
    pon = 12'h200; pof = 12'h100; mon = 12'h300; mof = 12'h100;
    tk(5);
    chk(frdy, 1); chk(ov, 0); chk(fca, 0); chk(flush, 0);
    tk(5);
    rst_n_i = 1'b1;
    $display("test reset done");
    foreach (rows[i]) run(rows[i]);
    $display("test decision table done");
    // fifo: stall the sink, fill until refused, then drain in order
    stall = 1'b1; n = 0; fv = 1'b1; dstp = 3'h0;
    for (int j = 0; j < 14; j++) begin
      ok = frdy; tk(1);
      if (ok) begin n++; dstp = 3'(n % 4); end
    end
    chk(frdy, 0);
    chk(n >= sptc_pkg::FIFO_DEPTH && n <= sptc_pkg::FIFO_DEPTH + 1, 1);
    fv = 1'b0; stall = 1'b0;
    for (int k = 0; k < n; k++) begin wait_got(); chk(last[2:0], k % 4); end
    tk(2); chk(ov, 0); chk(frdy, 1);
    $display("test fifo done");
    pl[0] = 12'h201; pl[1] = 12'h201; pl[2] = 12'h201; pl[3] = 12'h201; tk(2);
    chk(fca, 7'h03);
    chk(ps, 7'h01);
    chk(jm, 7'h02);
    chk(ph, 7'h71);
    pl[0] = 12'h150; pl[1] = 12'h150; tk(2); chk(fca, 7'h03);
    pl[1] = 12'h0ff; tk(2); chk(fca, 7'h01);
    gl = 12'h801; tk(2); chk(fca, 7'h73);
    chk(ps, 7'h71);
    gl = 12'h750; tk(2); chk(fca, 7'h73);
    gl = 12'h6ff; tk(2); chk(fca, 7'h01);
    pl[0] = 12'h000; tk(2); chk(fca, 7'h00);
    gl = 12'h400; rex = 7'h24; tk(2); chk(fca, 7'h20);
    rex = 7'h00; tk(2); chk(fca, 7'h00);
    rex = 7'h20; tk(2); chk(fca, 7'h20);
    gl = 12'h0ff; tk(2); chk(fca, 7'h00);
    $display("test flow control done");
    // member down plus a non-member down: only the member flushes
    lup[4] = 1'b0; lup[3] = 1'b0; flush_chk(4);
    r = rows[10]; r.ee = 3'h1; run(r);
    lup = 7'h7f; tk(2);
    spd[4] = 2'h2; flush_chk(4);
    run(r);
    spd[1] = 2'h1; flush_chk(1);
    r = rows[11]; r.ee = 3'h4; run(r);
    $display("test trunk failover done");
    end_of_test();
  end

  initial begin
    #3ms;
    error_cnt++;
    end_of_test();
  end
endmodule
